/* rtl/srap_consts.svh */
// Constants of the serial register access port
`ifndef SRAP_CONSTS_SVH
`define SRAP_CONSTS_SVH

`define SRAP_FRAME_BITS 5'd24
`define SRAP_CNT_W      5
`define SRAP_RW_BIT     23
`define SRAP_ADDR_HI    22
`define SRAP_ADDR_LO    16
`define SRAP_DATA_HI    15
`define SRAP_DATA_LO    0
`define SRAP_RW_WRITE   1'b0
`define SRAP_RW_READ    1'b1
`define SRAP_SYNC_W     3
`define SRAP_WORD_RST   24'h000000
`define SRAP_ADDR_RST   7'h00
`define SRAP_DATA_RST   16'h0000

`endif

/* rtl/srap_pkg.sv */
// Types shared by the serial register access port
`default_nettype none
package srap_pkg;
    // Host interface selection, locked by first protocol seen
    typedef enum logic [1:0] {
        SRAP_IF_NONE,
        SRAP_IF_SPI,
        SRAP_IF_OTHER
    } srap_if_t;
endpackage
`default_nettype wire

/* rtl/srap_sync.sv */
// Two-flop synchronisers for the serial pins
`include "srap_consts.svh"
`default_nettype none
module srap_sync
    import srap_pkg::*;
(
    // Clock and reset
    input  wire logic                    sys_clk_i,
    input  wire logic                    rst_b_i,
    // Asynchronous pins in, synchronised levels out
    input  wire logic [`SRAP_SYNC_W-1:0] async_i,
    output logic      [`SRAP_SYNC_W-1:0] sync_o
);
    logic [`SRAP_SYNC_W-1:0] meta_r;   // First stage, read only by sync_o

    // One pair of flops per pin; frame select idles high
    genvar g;
    for (g = 0; g < `SRAP_SYNC_W; g++) begin : g_bit
        always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
            if (!rst_b_i) begin
                meta_r[g] <= 1'b1;
                sync_o[g] <= 1'b1;
            end else begin
                meta_r[g] <= async_i[g];
                sync_o[g] <= meta_r[g];
            end
        end
    end
endmodule
`default_nettype wire

/* rtl/srap_txshift.sv */
// Readback shifter for the serial data output
`include "srap_consts.svh"
`default_nettype none
module srap_txshift
    import srap_pkg::*;
(
    // Clock and reset
    input  wire logic        sys_clk_i,
    input  wire logic        rst_b_i,
    // Control from the frame logic
    input  wire logic        load_i,
    input  wire logic [23:0] load_word_i,
    input  wire logic        rise_i,
    input  wire logic        fall_i,
    input  wire logic        out_edge_select_i,
    // Serial data level
    output logic             sdo_o
);
    logic [23:0] tx_r;   // Remaining bits, msb next
    logic        shift;  // Chosen clock edge seen

    // Edge select picks which serial clock edge advances the data
    assign shift = out_edge_select_i ? fall_i : rise_i; // R20

    // Load at frame start, then shift msb first
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            tx_r  <= `SRAP_WORD_RST;
            sdo_o <= 1'b0;
        end else if (load_i) begin
            // Falling-edge mode repeats the msb on the first edge, so that bit is not lost
            tx_r  <= out_edge_select_i ? load_word_i : {load_word_i[22:0], 1'b0}; // R20
            sdo_o <= load_word_i[`SRAP_RW_BIT];
        end else if (shift) begin
            tx_r  <= {tx_r[22:0], 1'b0};
            sdo_o <= tx_r[`SRAP_RW_BIT]; // R20
        end
    end
endmodule
`default_nettype wire

/* rtl/srap_top.sv */
// Serial register access port, device side
// Rules of the document for this interface
// [R1] First protocol after power-up locks interface
// [R2] Later protocol changes ignored until power cycle
// [R3] Output pin needs general pin as output
// [R4] Frame select falling starts a frame
// [R5] Works with continuous or gated serial clock
// [R6] Data input sampled on clock falling edges
// [R7] Host holds select for 24 falling edges
// [R8] Frame select rising ends and processes frame
// [R9] Fewer than 24 edges: frame discarded
// [R10] Output disabled after reset: three-wire
// [R11] Three-wire long frame: first 24 bits used
// [R12] Select high: ignore inputs, output high-Z
// [R13] First eight bits are instruction, msb first
// [R14] Instruction: direction flag, seven-bit address
// [R15] Last sixteen bits are the data
// [R16] Flag zero writes, flag one reads
// [R17] Write stores data at frame address
// [R18] Read ignores supplied data bits
// [R19] Readback needs enable, comes next frame
// [R20] Edge select picks output shift edge
// [R21] Returned frame echoes previous flag, address
// [R22] Host slows clock for readback frames
`include "srap_consts.svh"
`default_nettype none
module srap_top
    import srap_pkg::*;
(
    // Clock and reset
    input  wire logic        sys_clk_i,
    input  wire logic        rst_b_i,
    // Serial pins
    input  wire logic        sclk_i,
    input  wire logic        frame_sel_b_i,
    input  wire logic        sdi_i,
    output logic             sdo_o,
    output logic             sdo_oe_o,
    // Configuration levels
    input  wire logic        serial_out_enable_i,
    input  wire logic        gpio_is_sdo_i,
    input  wire logic        out_edge_select_i,
    input  wire logic        other_proto_i,
    // Register write port
    output logic             wr_en_o,
    output logic [6:0]       wr_addr_o,
    output logic [15:0]      wr_data_o,
    // Register read port
    output logic             rd_req_o,
    output logic [6:0]       rd_addr_o,
    input  wire logic [15:0] rd_data_i,
    // Status
    output logic             iface_spi_o,
    output logic             iface_locked_o
);
    // Synchronised pins and their delayed copies
    logic [`SRAP_SYNC_W-1:0] pins_s;      // {sdi, frame select, clock}
    logic                    sclk_s;      // Serial clock level
    logic                    sel_b_s;     // Frame select level
    logic                    sdi_s;       // Data input level
    logic                    sclk_d_r;    // Clock one cycle earlier
    logic                    sel_b_d_r;   // Select one cycle earlier
    // Decoded events
    logic                    sclk_fall;   // Falling clock edge
    logic                    sclk_rise;   // Rising clock edge
    logic                    frame_start; // Select fell
    logic                    frame_end;   // Select rose
    logic                    four_wire;   // Output path usable
    logic                    rx_shift;    // Take one data bit
    logic                    frame_ok;    // Full frame at end
    // Frame state
    srap_if_t                if_r;        // Locked interface
    logic                    in_frame_r;  // Inside an accepted frame
    logic [`SRAP_CNT_W-1:0]  cnt_r;       // Falling edges, saturating
    logic [23:0]             rx_r;        // Received bits
    // Echo of the previous accepted frame
    logic                    prev_rw_r;
    logic [6:0]              prev_addr_r;
    logic [15:0]             echo_r;
    logic [23:0]             tx_word;

    // Bring all three pins into the system clock domain
    srap_sync u_sync (
        .sys_clk_i (sys_clk_i),
        .rst_b_i   (rst_b_i),
        .async_i   ({sdi_i, frame_sel_b_i, sclk_i}),
        .sync_o    (pins_s)
    );
    assign sclk_s  = pins_s[0];
    assign sel_b_s = pins_s[1];
    assign sdi_s   = pins_s[2];

    // Delayed copies for edge finding
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            sclk_d_r  <= 1'b1;
            sel_b_d_r <= 1'b1;
        end else begin
            sclk_d_r  <= sclk_s;
            sel_b_d_r <= sel_b_s;
        end
    end

    // Edges come from sampling, so a stopped clock is just no edges
    assign sclk_fall   = sclk_d_r & ~sclk_s;  // R5
    assign sclk_rise   = ~sclk_d_r & sclk_s;  // R5
    assign frame_start = sel_b_d_r & ~sel_b_s; // R4
    assign frame_end   = ~sel_b_d_r & sel_b_s; // R8
    assign four_wire   = serial_out_enable_i & gpio_is_sdo_i; // R3
    // Three-wire stops at 24 bits; four-wire keeps the last 24
    assign rx_shift    = in_frame_r & ~sel_b_s & sclk_fall
                       & ((cnt_r < `SRAP_FRAME_BITS) | four_wire); // R6 R11
    // A host that stops early loses the frame entirely
    assign frame_ok    = in_frame_r & frame_end
                       & (cnt_r == `SRAP_FRAME_BITS); // R7 R9

    // Interface lock; both in one cycle favours the serial port
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            if_r <= SRAP_IF_NONE;
        end else if (if_r == SRAP_IF_NONE) begin
            if (frame_start) begin
                if_r <= SRAP_IF_SPI; // R1
            end else if (other_proto_i) begin
                if_r <= SRAP_IF_OTHER; // R1
            end
        end
        // Once chosen, nothing moves it until reset R2
    end

    // Frame window; only frames of the serial interface count
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            in_frame_r <= 1'b0;
        end else if (frame_start) begin
            in_frame_r <= (if_r != SRAP_IF_OTHER); // R2 R4
        end else if (sel_b_s) begin
            in_frame_r <= 1'b0; // R12
        end
    end

    // Bit counter and receive shifter, msb first
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cnt_r <= '0;
            rx_r  <= `SRAP_WORD_RST;
        end else if (frame_start) begin
            cnt_r <= '0;
            rx_r  <= `SRAP_WORD_RST;
        end else if (rx_shift) begin
            rx_r <= {rx_r[22:0], sdi_s}; // R6 R13
            // Saturate so long frames still count as full
            if (cnt_r < `SRAP_FRAME_BITS) begin
                cnt_r <= cnt_r + 5'd1; // R11
            end
        end
    end

    // Frame processing at select rising
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            wr_en_o   <= 1'b0;
            rd_req_o  <= 1'b0;
            wr_addr_o <= `SRAP_ADDR_RST;
            wr_data_o <= `SRAP_DATA_RST;
            rd_addr_o <= `SRAP_ADDR_RST;
        end else begin
            wr_en_o  <= 1'b0;
            rd_req_o <= 1'b0;
            if (frame_ok) begin // R8
                if (rx_r[`SRAP_RW_BIT] == `SRAP_RW_WRITE) begin // R16
                    wr_en_o   <= 1'b1; // R17
                    wr_addr_o <= rx_r[`SRAP_ADDR_HI:`SRAP_ADDR_LO]; // R14
                    wr_data_o <= rx_r[`SRAP_DATA_HI:`SRAP_DATA_LO]; // R15
                end else begin
                    // Data bits of a read are dropped here R18
                    rd_req_o  <= 1'b1; // R16
                    rd_addr_o <= rx_r[`SRAP_ADDR_HI:`SRAP_ADDR_LO]; // R14
                end
            end
        end
    end

    // Echo of the last accepted frame for the next readback
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            prev_rw_r   <= `SRAP_RW_WRITE;
            prev_addr_r <= `SRAP_ADDR_RST;
            echo_r      <= `SRAP_DATA_RST;
        end else if (frame_ok) begin
            prev_rw_r   <= rx_r[`SRAP_RW_BIT]; // R21
            prev_addr_r <= rx_r[`SRAP_ADDR_HI:`SRAP_ADDR_LO]; // R21
            echo_r      <= rx_r[`SRAP_DATA_HI:`SRAP_DATA_LO];
        end else if (rd_req_o) begin
            // Read data replaces the echo one cycle after the request
            echo_r <= rd_data_i; // R19
        end
    end

    // Returned word: flag, address, then data
    assign tx_word = {prev_rw_r, prev_addr_r, echo_r}; // R21

    // Output shifter, loaded when a frame opens
    srap_txshift u_tx (
        .sys_clk_i         (sys_clk_i),
        .rst_b_i           (rst_b_i),
        .load_i            (frame_start),
        .load_word_i       (tx_word),
        .rise_i            (sclk_rise & in_frame_r),
        .fall_i            (sclk_fall & in_frame_r),
        .out_edge_select_i (out_edge_select_i),
        .sdo_o             (sdo_o)
    );

    // Drive the output only inside a frame and only in four-wire use
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            sdo_oe_o <= 1'b0; // R10
        end else begin
            sdo_oe_o <= ~sel_b_s & four_wire
                      & (if_r == SRAP_IF_SPI); // R3 R12 R19
        end
    end

    // Status flags from the lock state
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            iface_spi_o    <= 1'b0;
            iface_locked_o <= 1'b0;
        end else begin
            iface_spi_o    <= (if_r == SRAP_IF_SPI);
            iface_locked_o <= (if_r != SRAP_IF_NONE);
        end
    end

    // Checks on the frame logic
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!rst_b_i);

    first_lock_a: assert property ( // R1
        (if_r == SRAP_IF_NONE) && frame_start |=> (if_r == SRAP_IF_SPI))
        else $error("first frame did not lock the serial interface");

    lock_hold_a: assert property ( // R2
        (if_r != SRAP_IF_NONE) |=> (if_r == $past(if_r)))
        else $error("locked interface changed");

    short_drop_a: assert property ( // R9
        frame_end && (cnt_r < `SRAP_FRAME_BITS) |=> !wr_en_o && !rd_req_o)
        else $error("short frame had an effect");

    full_frame_a: assert property ( // R8
        wr_en_o || rd_req_o |-> $past(cnt_r) == `SRAP_FRAME_BITS
                                && $past(frame_end))
        else $error("access without full frame at select rise");

    write_dir_a: assert property ( // R16
        wr_en_o |-> !$past(rx_r[`SRAP_RW_BIT]) && !rd_req_o)
        else $error("write issued for read flag");

    read_dir_a: assert property ( // R16
        rd_req_o |-> $past(rx_r[`SRAP_RW_BIT]) && !wr_en_o)
        else $error("read issued for write flag");

    write_word_a: assert property ( // R17
        wr_en_o |-> {wr_addr_o, wr_data_o} == $past(rx_r[22:0]))
        else $error("write address or data differs from frame");

    sample_fall_a: assert property ( // R6
        in_frame_r && !sel_b_s && sclk_fall && (cnt_r < `SRAP_FRAME_BITS)
        |=> rx_r[0] == $past(sdi_s) && cnt_r == $past(cnt_r) + 5'd1)
        else $error("data bit not taken on falling edge");

    long_hold_a: assert property ( // R11
        !four_wire && (cnt_r == `SRAP_FRAME_BITS) && !frame_start
        |=> $stable(rx_r) && cnt_r == `SRAP_FRAME_BITS)
        else $error("three-wire frame took more than 24 bits");

    idle_hiz_a: assert property ( // R12
        sel_b_s |=> !sdo_oe_o)
        else $error("output driven while deselected");

    oe_cause_a: assert property ( // R3
        sdo_oe_o |-> $past(serial_out_enable_i) && $past(gpio_is_sdo_i))
        else $error("output driven without four-wire setup");

    echo_load_a: assert property ( // R21
        frame_start |=> sdo_o == $past(prev_rw_r))
        else $error("returned frame does not open with echo flag");

    // Main scenarios
    write_cov_c: cover property (wr_en_o);
    read_cov_c:  cover property (rd_req_o ##[1:1000] frame_start);
    short_cov_c: cover property (frame_end && in_frame_r
                                 && (cnt_r < `SRAP_FRAME_BITS));
    other_cov_c: cover property (if_r == SRAP_IF_OTHER);
endmodule
`default_nettype wire

/* testbench/srap_host_model.sv */
// Host side serial master model for the register access port
`default_nettype none
module srap_host_model (
    // Serial pins towards the device
    output logic      sclk_o,
    output logic      frame_sel_b_o,
    output logic      sdi_o,
    // Device data out and its enable
    input  wire logic sdo_i,
    input  wire logic sdo_oe_i
);
    timeunit 1ns;
    timeprecision 100ps;

    logic [23:0] got_r;                          // Bits seen on the data out line
    wire         sdo_bus = sdo_oe_i ? sdo_i : ~sdo_i; // No pull: released line reads as inverse

    // Pins idle: select high, clock parked high
    initial begin
        sclk_o        = 1'b1;
        frame_sel_b_o = 1'b1;
        sdi_o         = 1'b0;
    end

    // One access cycle of nbits; half is the clock half period
    task automatic frame(input logic [31:0] word, input int nbits, input realtime half);
        int i;
        got_r         = 24'h000000;
        frame_sel_b_o = 1'b0;
        #(half);
        for (i = nbits - 1; i >= 0; i--) begin
            sdi_o  = word[i];
            #(half);
            sclk_o = 1'b0;
            #(half);
            // Sample just before rising, so the two output edges differ
            got_r  = {got_r[22:0], sdo_bus};
            sclk_o = 1'b1;
        end
        #(half);
        // Data line no longer valid: show the inverse, not the last bit
        sdi_o         = ~sdi_o;
        frame_sel_b_o = 1'b1;
    endtask

    // Free running clock and busy data while not selected
    task automatic idle(input int n);
        repeat (n) begin
            sdi_o  = ~sdi_o;
            #62.5;
            sclk_o = 1'b0;
            #62.5;
            sclk_o = 1'b1;
        end
    endtask
endmodule
`default_nettype wire

/* testbench/srap_top_test.sv */
// Self-checking bench of the serial register access port
`default_nettype none
module srap_top_test;
    timeunit 1ns;
    timeprecision 100ps;

    logic        sys_clk, rst_b, soe, gpio, edge_sel, other; // Bench driven
    wire         sclk, fsel_b, sdi, sdo, sdo_oe;             // Serial pins
    wire         wr_en, rd_req, if_spi, if_lock;             // Strobes, status
    wire  [6:0]  wr_addr, rd_addr;                           // Addresses
    wire  [15:0] wr_data, rd_data;                           // Data
    int          bad_count, check_count, wr_n, rd_n, oe_n, hi_n;

    // Read data source: address in the top bits, fixed pattern below
    assign rd_data = {rd_addr, 9'h0a5};

    srap_top dut (.sys_clk_i(sys_clk), .rst_b_i(rst_b), .sclk_i(sclk),
        .frame_sel_b_i(fsel_b), .sdi_i(sdi), .sdo_o(sdo), .sdo_oe_o(sdo_oe),
        .serial_out_enable_i(soe), .gpio_is_sdo_i(gpio), .out_edge_select_i(edge_sel),
        .other_proto_i(other), .wr_en_o(wr_en), .wr_addr_o(wr_addr), .wr_data_o(wr_data),
        .rd_req_o(rd_req), .rd_addr_o(rd_addr), .rd_data_i(rd_data),
        .iface_spi_o(if_spi), .iface_locked_o(if_lock));

    srap_host_model host (.sclk_o(sclk), .frame_sel_b_o(fsel_b), .sdi_o(sdi),
        .sdo_i(sdo), .sdo_oe_i(sdo_oe));

    // 200 MHz system clock
    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    // Compare and count
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    // Print counts and verdict, then stop
    task automatic finish_test;
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // One frame, then time for the strobe to land
    task automatic send(input logic [31:0] word, input int nbits, input realtime half);
        host.frame(word, nbits, half);
        repeat (12) @(posedge sys_clk);
    endtask

    // Count strobes; a long idle select must leave the output released
    always @(posedge sys_clk) begin
        if (wr_en === 1'b1) wr_n++;
        if (rd_req === 1'b1) rd_n++;
        if (sdo_oe === 1'b1) oe_n++;
        hi_n = (fsel_b === 1'b1) ? hi_n + 1 : 0;
        if (hi_n > 5 && sdo_oe !== 1'b0) begin
            bad_count++;
            $display("BAD %0t output driven while idle", $time);
        end
    end

    // Hang guard well inside the cycle budget
    initial begin
        #400000;
        bad_count++;
        $display("BAD %0t run did not finish", $time);
        finish_test();
    end

    // Reset held three cycles, released at a falling edge, then five cycles settle
    task automatic do_reset;
        rst_b = 1'b0;
        repeat (3) @(negedge sys_clk);
        rst_b = 1'b1;
        repeat (5) @(negedge sys_clk);
    endtask

    initial begin
        {soe, gpio, edge_sel, other} = 4'h0;
        do_reset();
        check(sdo_oe, 1'b0, "oe after reset");
        check(if_lock, 1'b0, "unlocked after reset");
        // Plain write, three-wire
        send(32'h002ac35a, 24, 62.5);
        check(wr_n, 1, "write strobe");
        check(wr_addr, 7'h2a, "write address");
        check(wr_data, 16'hc35a, "write data");
        check(if_spi, 1'b1, "serial locked");
        check(oe_n, 0, "output off in three-wire");
        $display("test write done");
        // One edge short: dropped; long frame: first 24 bits only
        send(32'h00123456, 23, 62.5);
        check(wr_n + rd_n, 1, "short frame ignored");
        send(32'h01b0f0f5, 28, 62.5);
        check({wr_addr, wr_data}, {7'h1b, 16'h0f0f}, "long frame");
        $display("test frame length done");
        // Clock runs free while deselected, then a read with junk data
        host.idle(8);
        check(wr_n + rd_n, 2, "idle clock ignored");
        // Output enable alone, without the general pin, must not drive
        @(negedge sys_clk) soe = 1'b1;
        send(32'h00b3ffff, 24, 100.0);
        check(rd_n, 1, "read strobe");
        check(wr_n, 2, "no write on read");
        check(oe_n, 0, "no output without pin");
        check(rd_addr, 7'h33, "read address");
        check(wr_data, 16'h0f0f, "read leaves data");
        @(negedge sys_clk) other = 1'b1;
        @(negedge sys_clk) other = 1'b0;
        // Give the lock state and its status flop time to react
        repeat (2) @(negedge sys_clk);
        check(if_spi, 1'b1, "lock kept");
        $display("test read done");
        // Four-wire readback on rising then falling output edge
        @(negedge sys_clk) {soe, gpio} = 2'h3;
        send(32'h004a1234, 24, 100.0);
        check(host.got_r, {1'b1, 7'h33, 7'h33, 9'h0a5}, "read echo");
        check(oe_n > 0, 1'b1, "output driven");
        @(negedge sys_clk) edge_sel = 1'b1;
        send(32'h00000000, 24, 100.0);
        check(host.got_r, 24'h4a1234, "falling edge echo");
        $display("test readback done");
        // Other protocol first after a new reset: serial frames ignored
        do_reset();
        @(negedge sys_clk) other = 1'b1;
        @(negedge sys_clk) other = 1'b0;
        send(32'h00111111, 24, 62.5);
        check({if_lock, if_spi}, 2'h2, "other protocol locked");
        check(wr_n, 4, "serial frame refused");
        $display("test lock done");
        finish_test();
    end
endmodule
`default_nettype wire
